// ==== pkg/lfe_pkg.sv ====
`default_nettype none
package lfe_pkg;

    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [15:0] EMISSION_CONFIG_IDX   = 16'hFE8F;
    localparam logic [15:0] FRONT_END_CONTROL_IDX = 16'hFE90;
    localparam int          REG_W                 = 8;
    localparam int          DATA_W                = 32;
    localparam logic [7:0]  EMISSION_CONFIG_RST   = 8'h03;
    localparam logic [7:0]  FRONT_END_CONTROL_RST = 8'h10;
    localparam logic [7:0]  EMISSION_CONFIG_MASK  = 8'h03;
    localparam logic [7:0]  FRONT_END_CONTROL_MASK = 8'h1F;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int TWO_BRIDGES_BIT       = 0;
    localparam int EMISSION_MODE_SEL_BIT = 1;
    localparam int TRX_PIN_INVERT_BIT    = 0;
    localparam int TRX_HW_CONTROL_BIT    = 1;
    localparam int TRX_LEVEL_BIT         = 2;
    localparam int BRANCH_PIN_INVERT_BIT = 3;
    localparam int BRANCH_SELECT_BIT     = 4;

    // ************************************************************
    // Emission output layout.
    // ************************************************************
    localparam int EMIT_N     = 12;
    localparam int GROUP_SIZE = 3;
    localparam int HALF_SIZE  = 6;

endpackage : lfe_pkg
`default_nettype wire

// ==== hw/lfe_front_end.sv ====
`timescale 1ns/1ps
`default_nettype none
module lfe_front_end #(
    parameter int ADDR_W = 18
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           ce,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [ADDR_W-1:0]              paddr,
    input  wire logic [lfe_pkg::DATA_W-1:0]     pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [lfe_pkg::DATA_W-1:0]     prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           tx_p_drive,
    input  wire logic                           tx_n_drive,
    input  wire logic                           tx_active,
    output logic      [lfe_pkg::EMIT_N-1:0]     emission_out,
    output logic                                int_drv_p,
    output logic                                int_drv_n,
    output logic                                int_drv_en,
    output logic                                branch_pin,
    output logic                                trx_pin
);

    // ************************************************************
    // Bus slave.
    // ************************************************************
    logic [lfe_pkg::REG_W-1:0]   emission_config_ff;
    logic [lfe_pkg::REG_W-1:0]   front_end_control_ff;
    logic [lfe_pkg::REG_W-1:0]   nxt_emission_config;
    logic [lfe_pkg::REG_W-1:0]   nxt_front_end_control;
    logic [lfe_pkg::DATA_W-1:0]  prdata_ff;
    logic [lfe_pkg::DATA_W-1:0]  nxt_prdata;
    logic                        pready_ff;
    logic                        nxt_pready;
    logic                        pslverr_ff;
    logic                        nxt_pslverr;
    logic                        hit_emit;
    logic                        hit_afe;
    logic                        done;

    // Byte address is four times the register index.
    assign hit_emit = (paddr == ADDR_W'({lfe_pkg::EMISSION_CONFIG_IDX, 2'b00}));
    assign hit_afe  = (paddr == ADDR_W'({lfe_pkg::FRONT_END_CONTROL_IDX, 2'b00}));
    assign done     = psel & penable & pready_ff;

    always_comb begin
        nxt_emission_config   = emission_config_ff;
        nxt_front_end_control = front_end_control_ff;
        nxt_prdata            = prdata_ff;
        nxt_pslverr           = 1'b0;
        nxt_pready            = psel & penable & ~pready_ff;
        if (psel & penable & ~pready_ff) begin
            nxt_pslverr = ~(hit_emit | hit_afe);
            nxt_prdata  = '0;
            if (hit_emit) begin
                nxt_prdata[lfe_pkg::REG_W-1:0] = emission_config_ff;
            end
            if (hit_afe) begin
                nxt_prdata[lfe_pkg::REG_W-1:0] = front_end_control_ff;
            end
        end
        if (done & pwrite & pstrb[0]) begin
            if (hit_emit) begin
                nxt_emission_config = pwdata[lfe_pkg::REG_W-1:0] & lfe_pkg::EMISSION_CONFIG_MASK;
            end
            if (hit_afe) begin
                nxt_front_end_control = pwdata[lfe_pkg::REG_W-1:0] & lfe_pkg::FRONT_END_CONTROL_MASK;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emission_config_ff   <= lfe_pkg::EMISSION_CONFIG_RST;
            front_end_control_ff <= lfe_pkg::FRONT_END_CONTROL_RST;
            prdata_ff            <= '0;
            pready_ff            <= 1'b0;
            pslverr_ff           <= 1'b0;
        end else if (ce) begin
            emission_config_ff   <= nxt_emission_config;
            front_end_control_ff <= nxt_front_end_control;
            prdata_ff            <= nxt_prdata;
            pready_ff            <= nxt_pready;
            pslverr_ff           <= nxt_pslverr;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = pready_ff;
    assign pslverr = pslverr_ff;

    // ************************************************************
    // Front end pin control.
    // ************************************************************
    logic                          emission_mode_sel;
    logic                          two_bridges;
    logic                          branch_select;
    logic                          branch_pin_invert;
    logic                          trx_level;
    logic                          trx_hw_control;
    logic                          trx_pin_invert;
    logic [lfe_pkg::EMIT_N-1:0]    emission_out_ff;
    logic [lfe_pkg::EMIT_N-1:0]    nxt_emission_out;
    logic                          int_drv_p_ff;
    logic                          int_drv_n_ff;
    logic                          int_drv_en_ff;
    logic                          branch_pin_ff;
    logic                          trx_pin_ff;
    logic                          nxt_int_drv_p;
    logic                          nxt_int_drv_n;
    logic                          nxt_int_drv_en;
    logic                          nxt_branch_pin;
    logic                          nxt_trx_pin;

    assign emission_mode_sel = emission_config_ff[lfe_pkg::EMISSION_MODE_SEL_BIT];
    assign two_bridges       = emission_config_ff[lfe_pkg::TWO_BRIDGES_BIT];
    assign branch_select     = front_end_control_ff[lfe_pkg::BRANCH_SELECT_BIT];
    assign branch_pin_invert = front_end_control_ff[lfe_pkg::BRANCH_PIN_INVERT_BIT];
    assign trx_level         = front_end_control_ff[lfe_pkg::TRX_LEVEL_BIT];
    assign trx_hw_control    = front_end_control_ff[lfe_pkg::TRX_HW_CONTROL_BIT];
    assign trx_pin_invert    = front_end_control_ff[lfe_pkg::TRX_PIN_INVERT_BIT];

    // With two bridges, each output is placed by its group of three: P1, N1, P2, N2; with one bridge, by its half: P low, N high.
    for (genvar i = 0; i < lfe_pkg::EMIT_N; i++) begin : g_emit
        localparam int GRP = i / lfe_pkg::GROUP_SIZE;
        logic leg_drive;
        logic leg_on;
        assign leg_drive = two_bridges ? ((GRP % 2 == 0) ? tx_p_drive : tx_n_drive)
                                       : ((i < lfe_pkg::HALF_SIZE) ? tx_p_drive : tx_n_drive);
        assign leg_on    = ~two_bridges | ((GRP < 2) == branch_select);
        assign nxt_emission_out[i] = emission_mode_sel & leg_on & leg_drive;
    end

    always_comb begin
        nxt_int_drv_en = ~emission_mode_sel;
        nxt_int_drv_p  = ~emission_mode_sel & tx_p_drive;
        nxt_int_drv_n  = ~emission_mode_sel & tx_n_drive;
        nxt_branch_pin = branch_select ^ branch_pin_invert;
        nxt_trx_pin    = (trx_hw_control ? tx_active : trx_level) ^ trx_pin_invert;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emission_out_ff <= '0;
            int_drv_p_ff    <= 1'b0;
            int_drv_n_ff    <= 1'b0;
            int_drv_en_ff   <= 1'b0;
            branch_pin_ff   <= 1'b0;
            trx_pin_ff      <= 1'b0;
        end else if (ce) begin
            emission_out_ff <= nxt_emission_out;
            int_drv_p_ff    <= nxt_int_drv_p;
            int_drv_n_ff    <= nxt_int_drv_n;
            int_drv_en_ff   <= nxt_int_drv_en;
            branch_pin_ff   <= nxt_branch_pin;
            trx_pin_ff      <= nxt_trx_pin;
        end
    end

    assign emission_out = emission_out_ff;
    assign int_drv_p    = int_drv_p_ff;
    assign int_drv_n    = int_drv_n_ff;
    assign int_drv_en   = int_drv_en_ff;
    assign branch_pin   = branch_pin_ff;
    assign trx_pin      = trx_pin_ff;

    // ************************************************************
    // Assertions.
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ext_mode;
        ce && emission_mode_sel;
    endsequence

    sequence s_int_mode;
        ce && !emission_mode_sel;
    endsequence

    property p_internal_driver;
        s_int_mode |=> int_drv_en && (emission_out == '0) && (int_drv_p == $past(tx_p_drive));
    endproperty
    a_internal_driver: assert property (p_internal_driver) else $error("Internal mode misdriven.");

    property p_external_quiet;
        s_ext_mode |=> !int_drv_en && !int_drv_p && !int_drv_n;
    endproperty
    a_external_quiet: assert property (p_external_quiet) else $error("Internal driver active in external mode.");

    property p_one_bridge;
        s_ext_mode ##0 !two_bridges |=>
            (emission_out == {{6{$past(tx_n_drive)}}, {6{$past(tx_p_drive)}}});
    endproperty
    a_one_bridge: assert property (p_one_bridge) else $error("Single bridge mapping wrong.");

    property p_high_branch;
        s_ext_mode ##0 two_bridges && branch_select |=>
            (emission_out == {6'h00, {3{$past(tx_n_drive)}}, {3{$past(tx_p_drive)}}});
    endproperty
    a_high_branch: assert property (p_high_branch) else $error("High impedance branch mapping wrong.");

    property p_low_branch;
        s_ext_mode ##0 two_bridges && !branch_select |=>
            (emission_out == {{3{$past(tx_n_drive)}}, {3{$past(tx_p_drive)}}, 6'h00});
    endproperty
    a_low_branch: assert property (p_low_branch) else $error("Low impedance branch mapping wrong.");

    property p_branch_pin;
        ce |=> branch_pin == ($past(branch_select) ^ $past(branch_pin_invert));
    endproperty
    a_branch_pin: assert property (p_branch_pin) else $error("Branch pin level wrong.");

    property p_trx_pin;
        ce |=> trx_pin == (($past(trx_hw_control) ? $past(tx_active) : $past(trx_level))
                           ^ $past(trx_pin_invert));
    endproperty
    a_trx_pin: assert property (p_trx_pin) else $error("Transmit receive pin level wrong.");

    property p_freeze;
        !ce |=> $stable(emission_out) && $stable(trx_pin) && $stable(front_end_control_ff);
    endproperty
    a_freeze: assert property (p_freeze) else $error("State moved while clock enable low.");

endmodule : lfe_front_end
`default_nettype wire

// ==== sim/lfe_bridge_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lfe_bridge_model (
    input  wire logic [lfe_pkg::EMIT_N-1:0] emission_out,
    output logic      [3:0]                 leg_on
);
    // ************************************************************
    // Bridge legs.
    // ************************************************************
    // Each leg conducts only when its three transistors are all on.
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            leg_on[k] = &emission_out[k*3 +: 3];
        end
    end
endmodule : lfe_bridge_model
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ************************************************************
    // Stimulus and checking.
    // ************************************************************
    logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [3:0]  pstrb = 4'h0, leg_on;
    logic        tx_p = 1'b0, tx_n = 1'b0, tx_act = 1'b0;
    logic        pready, pslverr, drv_p, drv_n, drv_en, branch_pin, trx_pin;
    logic [11:0] emission_out;
    logic [7:0]  ec, fc;
    logic [33:0] exp_q[$];
    logic [33:0] note;
    int          n_fail = 0, total_checks = 0, seed = 98806, cycles = 0;
    always #20 pclk = ~pclk;
    lfe_front_end #(.ADDR_W(18)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_p_drive(tx_p), .tx_n_drive(tx_n), .tx_active(tx_act), .emission_out(emission_out),
        .int_drv_p(drv_p), .int_drv_n(drv_n), .int_drv_en(drv_en), .branch_pin(branch_pin), .trx_pin(trx_pin));
    lfe_bridge_model mdl (.emission_out(emission_out), .leg_on(leg_on));
    task end_of_test;
        $display("Checks %0d, failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: bus got %h exp %h", $time, got, exp);
        end
    endtask : cmp_bus
    task cmp_pin(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: pins got %h exp %h", $time, got, exp);
        end
    endtask : cmp_pin
    task apb(input logic wr, input logic [17:0] a, input logic [31:0] wd, input logic [3:0] s, input logic [33:0] n);
        @(posedge pclk);
        exp_q.push_back(n);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && cycles < 5000);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task rd_both;
        apb(1'b0, {lfe_pkg::EMISSION_CONFIG_IDX, 2'b00}, 32'h0, 4'h0, {2'b10, 24'h0, ec});
        apb(1'b0, {lfe_pkg::FRONT_END_CONTROL_IDX, 2'b00}, 32'h0, 4'h0, {2'b10, 24'h0, fc});
    endtask : rd_both
    task pins(input logic [2:0] r, input logic frz);
        logic [11:0] e;
        @(posedge pclk);
        ce <= 1'b1; tx_p <= r[0]; tx_n <= r[1]; tx_act <= r[2];
        @(posedge pclk);
        if (frz) begin
            ce <= 1'b0; tx_p <= ~r[0]; tx_n <= ~r[1]; tx_act <= ~r[2];
            repeat (3) @(posedge pclk);
        end
        #1;
        if (!ec[1]) e = 12'h000;
        else if (!ec[0]) e = {{6{r[1]}}, {6{r[0]}}};
        else if (fc[4]) e = {6'h00, {3{r[1]}}, {3{r[0]}}};
        else e = {{3{r[1]}}, {3{r[0]}}, 6'h00};
        cmp_pin({5'h0, emission_out, drv_en, drv_p, drv_n}, {5'h0, e, ~ec[1], ~ec[1] & r[0], ~ec[1] & r[1]});
        cmp_pin({16'h0, leg_on}, {16'h0, &e[11:9], &e[8:6], &e[5:3], &e[2:0]});
        cmp_pin({18'h0, branch_pin, trx_pin}, {18'h0, fc[4] ^ fc[3], (fc[1] ? r[2] : fc[2]) ^ fc[0]});
        if (frz) begin
            @(posedge pclk);
            ce <= 1'b1;
        end
    endtask : pins
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            cmp_bus({pslverr, note[33] ? prdata : 32'h0}, note[32:0]);
        end
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            end_of_test;
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        ec = 8'h03;
        fc = 8'h10;
        pins(3'b111, 1'b0);
        rd_both;
        apb(1'b1, 18'h00010, 32'hFF, 4'hF, {2'b01, 32'h0});
        apb(1'b0, 18'h00010, 32'h0, 4'h0, {2'b11, 32'h0});
        apb(1'b1, {lfe_pkg::EMISSION_CONFIG_IDX, 2'b00}, 32'h0, 4'h0, {2'b00, 32'h0});
        rd_both;
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            d[1:0] = i[1:0];
            apb(1'b1, {lfe_pkg::EMISSION_CONFIG_IDX, 2'b00}, d, 4'hF, {2'b00, 32'h0});
            ec = d[7:0] & lfe_pkg::EMISSION_CONFIG_MASK;
            d = $random(seed);
            d[4] = i[2];
            d[1] = i[3];
            apb(1'b1, {lfe_pkg::FRONT_END_CONTROL_IDX, 2'b00}, d, 4'hF, {2'b00, 32'h0});
            fc = d[7:0] & lfe_pkg::FRONT_END_CONTROL_MASK;
            rd_both;
            repeat (3) begin
                d = $random(seed);
                pins(d[2:0], i[0]);
            end
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        ec = 8'h03;
        fc = 8'h10;
        rd_both;
        pins(3'b101, 1'b0);
        end_of_test;
    end
endmodule : tb
`default_nettype wire
